// ==== ucrm_bank.sv ====
// Register bank of one serial channel with host bus decode and interrupt status
`timescale 1ns/1ns
module ucrm_bank
  import ucrm_pkg::*;
#(
  parameter logic [7:0] REV_CODE = 8'h01,
  parameter logic [7:0] DEV_IDENT = 8'h5A,
  parameter int CHANNEL = 0
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Host bus pins
  input wire logic channel_a_select_n_i,
  input wire logic channel_b_select_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic rdata_valid_o,
  output logic irq_o,
  // Channel core status
  input wire ucrm_core_t core_i,
  // Channel core control
  output logic tx_push_o,
  output logic [7:0] tx_data_o,
  output logic rx_pop_o,
  output logic rx_fifo_reset_o,
  output logic tx_fifo_reset_o,
  output logic fifo_en_o,
  output logic [1:0] rx_trigger_o,
  output logic [7:0] line_control_o,
  output logic [15:0] divisor_o,
  output logic [7:0] modem_control_o,
  output logic [7:0] enhanced_function_o
);
  if (CHANNEL < 0 || CHANNEL > 1) begin : g_channel_check
    $error("CHANNEL must be 0 or 1");
  end

  typedef struct packed {
    ucrm_bus_t bus_s1;
    ucrm_bus_t bus_s2;
    logic sel_s1;
    logic sel_s2;
    logic rd_d;
    logic wr_d;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] line_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] enhanced_function_reg;
    logic [7:0] scratch_pad;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] resume_char_one;
    logic [7:0] resume_char_two;
    logic [7:0] pause_char_one;
    logic [7:0] pause_char_two;
    logic fifo_en;
    logic dma_mode;
    logic [1:0] rx_trig;
    logic [1:0] tx_trig;
    logic rx_ready;
    logic overrun;
    logic tx_armed;
    logic tx_empty_d;
    logic line_armed;
    logic [7:0] rdata;
    logic rdata_valid;
    logic irq;
    logic tx_push;
    logic [7:0] tx_data;
    logic rx_pop;
    logic rx_rst;
    logic tx_rst;
  } ucrm_state_t;

  ucrm_state_t s_q, s_d;
  logic [4:0] trig_level;
  logic rx_level_hit;
  logic enh;
  logic div_bank;
  logic xbank;
  logic [7:0] line_status;
  logic [5:0] isr_code;
  logic [7:0] isr_val;
  logic rd_edge, wr_edge;
  logic src_line, src_rx, src_tx, src_modem;

  always_comb begin
    unique case (s_q.rx_trig)
      2'h0: trig_level = 5'h01;
      2'h1: trig_level = 5'h04;
      2'h2: trig_level = 5'h08;
      default: trig_level = 5'h0E;
    endcase
  end

  assign enh = s_q.enhanced_function_reg[UCRM_EFR_ENH_BIT];
  assign xbank = (s_q.line_control_reg == UCRM_LCR_ENH_BANK);
  assign div_bank = s_q.line_control_reg[UCRM_LCR_DIV_BIT] && !xbank;
  assign rx_level_hit = s_q.fifo_en ? (core_i.rx_level >= trig_level) : s_q.rx_ready;
  assign rd_edge = s_q.bus_s2.rd && !s_q.rd_d && s_q.sel_s2;
  assign wr_edge = s_q.bus_s2.wr && !s_q.wr_d && s_q.sel_s2;

  // Line status word
  assign line_status = {core_i.rx_err_present && s_q.fifo_en,
                        core_i.tx_fifo_empty && core_i.tx_shift_empty,
                        core_i.tx_fifo_empty,
                        core_i.rx_head_err,
                        s_q.overrun,
                        s_q.rx_ready};

  // Interrupt sources gated by enables
  assign src_line = s_q.interrupt_enable_reg[2] && s_q.line_armed;
  assign src_rx = s_q.interrupt_enable_reg[0] && rx_level_hit;
  assign src_tx = s_q.interrupt_enable_reg[1] && s_q.tx_armed;
  assign src_modem = s_q.interrupt_enable_reg[3] && (|core_i.modem_status[3:0]);

  always_comb begin
    if (src_line) begin
      isr_code = UCRM_ISR_LINE;
    end else if (src_rx) begin
      isr_code = UCRM_ISR_RXRDY;
    end else if (src_tx) begin
      isr_code = UCRM_ISR_TXRDY;
    end else if (src_modem) begin
      isr_code = UCRM_ISR_MODEM;
    end else begin
      isr_code = UCRM_ISR_NONE;
    end
  end
  assign isr_val = {{2{s_q.fifo_en}}, isr_code & ~(enh ? 6'h00 : UCRM_ISR_ENH_MASK[5:0])};

  always_comb begin
    s_d = s_q;
    // Two flip-flops on every host pin
    s_d.bus_s1 = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    s_d.bus_s2 = s_q.bus_s1;
    s_d.sel_s1 = (CHANNEL == 0) ? !channel_a_select_n_i : !channel_b_select_n_i;
    s_d.sel_s2 = s_q.sel_s1;
    s_d.rd_d = s_q.bus_s2.rd;
    s_d.wr_d = s_q.bus_s2.wr;
    s_d.tx_push = 1'b0;
    s_d.rx_pop = 1'b0;
    s_d.rx_rst = 1'b0;
    s_d.tx_rst = 1'b0;
    s_d.rdata_valid = 1'b0;
    s_d.irq = (isr_code != UCRM_ISR_NONE);

    // Data ready and overrun tracking
    if (core_i.rx_push) begin
      s_d.rx_ready = 1'b1;
    end else if (core_i.rx_level == 5'h00 || (s_q.rx_pop && core_i.rx_level <= 5'h01)) begin
      s_d.rx_ready = 1'b0;
    end
    s_d.tx_empty_d = core_i.tx_fifo_empty;
    if (|line_status[4:1] && !s_q.line_armed) begin
      s_d.line_armed = 1'b1;
    end

    if (rd_edge) begin
      s_d.rdata_valid = 1'b1;
      s_d.rdata = UCRM_RESET_ZERO;
      unique case (s_q.bus_s2.addr)
        UCRM_ADDR_HOLD: begin
          if (div_bank) begin
            s_d.rdata = ({s_q.divisor_high, s_q.divisor_low} == 16'h0000) ? REV_CODE : s_q.divisor_low;
          end else begin
            s_d.rdata = core_i.rx_head_data;
            s_d.rx_pop = s_q.rx_ready;
          end
        end
        UCRM_ADDR_IER: begin
          if (div_bank) begin
            s_d.rdata = ({s_q.divisor_high, s_q.divisor_low} == 16'h0000) ? DEV_IDENT : s_q.divisor_high;
          end else begin
            s_d.rdata = s_q.interrupt_enable_reg & (enh ? 8'hFF : UCRM_IER_STD_MASK);
          end
        end
        UCRM_ADDR_ISR: begin
          if (xbank) begin
            s_d.rdata = s_q.enhanced_function_reg;
          end else begin
            s_d.rdata = isr_val;
            if (isr_code == UCRM_ISR_TXRDY) begin
              s_d.tx_armed = 1'b0;
            end
          end
        end
        UCRM_ADDR_LCR: s_d.rdata = s_q.line_control_reg;
        UCRM_ADDR_MCR: s_d.rdata = xbank ? s_q.resume_char_one
                                         : s_q.modem_control_reg & (enh ? 8'hFF : UCRM_MCR_STD_MASK);
        UCRM_ADDR_LSR: begin
          s_d.rdata = xbank ? s_q.resume_char_two : line_status;
          if (!xbank) begin
            s_d.overrun = 1'b0;
            s_d.line_armed = 1'b0;
          end
        end
        UCRM_ADDR_MSR: s_d.rdata = xbank ? s_q.pause_char_one : core_i.modem_status;
        default: s_d.rdata = xbank ? s_q.pause_char_two : s_q.scratch_pad;
      endcase
    end

    if (wr_edge) begin
      unique case (s_q.bus_s2.addr)
        UCRM_ADDR_HOLD: begin
          if (div_bank) begin
            s_d.divisor_low = s_q.bus_s2.wdata;
          end else begin
            s_d.tx_push = 1'b1;
            s_d.tx_data = s_q.bus_s2.wdata;
            s_d.tx_armed = 1'b0;
          end
        end
        UCRM_ADDR_IER: begin
          if (div_bank) begin
            s_d.divisor_high = s_q.bus_s2.wdata;
          end else begin
            s_d.interrupt_enable_reg = s_q.bus_s2.wdata & (enh ? 8'hFF : UCRM_IER_STD_MASK);
            if (s_q.bus_s2.wdata[1] && !s_q.interrupt_enable_reg[1]) begin
              s_d.tx_armed = core_i.tx_fifo_empty;
            end
          end
        end
        UCRM_ADDR_ISR: begin
          if (xbank) begin
            s_d.enhanced_function_reg = s_q.bus_s2.wdata;
          end else begin
            s_d.fifo_en = s_q.bus_s2.wdata[0];
            if (s_q.bus_s2.wdata[0]) begin
              s_d.rx_rst = s_q.bus_s2.wdata[1];
              s_d.tx_rst = s_q.bus_s2.wdata[2];
              s_d.dma_mode = s_q.bus_s2.wdata[3];
              s_d.rx_trig = s_q.bus_s2.wdata[7:6];
              if (enh) begin
                s_d.tx_trig = s_q.bus_s2.wdata[5:4];
              end
            end
          end
        end
        UCRM_ADDR_LCR: s_d.line_control_reg = s_q.bus_s2.wdata;
        UCRM_ADDR_MCR: begin
          if (xbank) begin
            s_d.resume_char_one = s_q.bus_s2.wdata;
          end else begin
            s_d.modem_control_reg = s_q.bus_s2.wdata & (enh ? 8'hFF : UCRM_MCR_STD_MASK);
          end
        end
        UCRM_ADDR_LSR: if (xbank) s_d.resume_char_two = s_q.bus_s2.wdata;
        UCRM_ADDR_MSR: if (xbank) s_d.pause_char_one = s_q.bus_s2.wdata;
        default: begin
          if (xbank) begin
            s_d.pause_char_two = s_q.bus_s2.wdata;
          end else begin
            s_d.scratch_pad = s_q.bus_s2.wdata;
          end
        end
      endcase
    end
    if (s_d.rx_rst) begin
      s_d.rx_ready = 1'b0;
    end
    // Overrun set wins over read clear
    if (core_i.rx_overrun) begin
      s_d.overrun = 1'b1;
    end
    // Transmit ready arms once as the transmit FIFO drains
    if (core_i.tx_fifo_empty && !s_q.tx_empty_d) begin
      s_d.tx_armed = 1'b1;
    end
    if (core_i.rx_push) begin
      s_d.rx_ready = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.line_control_reg <= UCRM_LCR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign rdata_valid_o = s_q.rdata_valid;
  assign irq_o = s_q.irq;
  assign tx_push_o = s_q.tx_push;
  assign tx_data_o = s_q.tx_data;
  assign rx_pop_o = s_q.rx_pop;
  assign rx_fifo_reset_o = s_q.rx_rst;
  assign tx_fifo_reset_o = s_q.tx_rst;
  assign fifo_en_o = s_q.fifo_en;
  assign rx_trigger_o = s_q.rx_trig;
  assign line_control_o = s_q.line_control_reg;
  assign divisor_o = {s_q.divisor_high, s_q.divisor_low};
  assign modem_control_o = s_q.modem_control_reg;
  assign enhanced_function_o = s_q.enhanced_function_reg;

  rx_trigger_irq_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    s_q.fifo_en && s_q.interrupt_enable_reg[0] && core_i.rx_level >= trig_level |=> irq_o)
    else $error("receive trigger did not raise interrupt");
  irq_clear_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (isr_code == UCRM_ISR_NONE) |=> !irq_o)
    else $error("interrupt stayed with nothing pending");
  data_ready_set_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    core_i.rx_push |=> s_q.rx_ready)
    else $error("data ready not set on push");
  overrun_set_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    core_i.rx_overrun |=> line_status[1])
    else $error("overrun not reported");
  tx_empty_bit_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    rd_edge && s_q.bus_s2.addr == UCRM_ADDR_LSR && !xbank
    |=> rdata_o[6] == $past(core_i.tx_fifo_empty && core_i.tx_shift_empty))
    else $error("transmit idle bit wrong");
  enh_ier_zero_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    rd_edge && s_q.bus_s2.addr == UCRM_ADDR_IER && !div_bank && !enh |=> rdata_o[7:4] == 4'h0)
    else $error("enhanced enable bits read back");
  hold_write_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_edge && s_q.bus_s2.addr == UCRM_ADDR_HOLD && !div_bank |=> tx_push_o ##1 !tx_push_o)
    else $error("holding write not pushed once");
  fcr_gate_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_edge && s_q.bus_s2.addr == UCRM_ADDR_ISR && !xbank && !s_q.bus_s2.wdata[0] |=> $stable(s_q.rx_trig))
    else $error("trigger changed without enable");
  line_priority_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    rd_edge && s_q.bus_s2.addr == UCRM_ADDR_ISR && !xbank && src_line |=> rdata_o[3:0] == UCRM_ISR_LINE[3:0])
    else $error("line status not highest priority");
endmodule

// ==== ucrm_pkg.sv ====
// Package with register map constants and carrier types for the channel register bank
package ucrm_pkg;
  localparam logic [2:0] UCRM_ADDR_HOLD = 3'h0;
  localparam logic [2:0] UCRM_ADDR_IER = 3'h1;
  localparam logic [2:0] UCRM_ADDR_ISR = 3'h2;
  localparam logic [2:0] UCRM_ADDR_LCR = 3'h3;
  localparam logic [2:0] UCRM_ADDR_MCR = 3'h4;
  localparam logic [2:0] UCRM_ADDR_LSR = 3'h5;
  localparam logic [2:0] UCRM_ADDR_MSR = 3'h6;
  localparam logic [2:0] UCRM_ADDR_SPR = 3'h7;
  localparam logic [7:0] UCRM_LCR_ENH_BANK = 8'hBF;
  localparam int UCRM_LCR_DIV_BIT = 7;
  localparam int UCRM_EFR_ENH_BIT = 4;
  localparam logic [7:0] UCRM_IER_STD_MASK = 8'h0F;
  localparam logic [7:0] UCRM_ISR_ENH_MASK = 8'h30;
  localparam logic [7:0] UCRM_FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] UCRM_MCR_STD_MASK = 8'h1F;
  localparam logic [7:0] UCRM_RESET_ZERO = 8'h00;
  localparam logic [7:0] UCRM_LCR_RESET = 8'h03;
  localparam logic [5:0] UCRM_ISR_NONE = 6'h01;
  localparam logic [5:0] UCRM_ISR_LINE = 6'h06;
  localparam logic [5:0] UCRM_ISR_RXRDY = 6'h04;
  localparam logic [5:0] UCRM_ISR_TXRDY = 6'h02;
  localparam logic [5:0] UCRM_ISR_MODEM = 6'h00;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ucrm_bus_t;

  typedef struct packed {
    logic [4:0] rx_level;
    logic rx_err_present;
    logic [2:0] rx_head_err;
    logic rx_overrun;
    logic rx_push;
    logic tx_fifo_empty;
    logic tx_shift_empty;
    logic [7:0] rx_head_data;
    logic [7:0] modem_status;
  } ucrm_core_t;
endpackage

// ==== ucrm_host.sv ====
// Host processor model driving the channel register bus
`timescale 1ns/1ns
module ucrm_host (
  // Clock
  input wire logic ref_clk_i,
  // Read return
  input wire logic [7:0] rdata_i,
  input wire logic rdata_valid_i,
  // Bus drive
  output logic sel_a_n_o,
  output logic sel_b_n_o,
  output logic [2:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    sel_a_n_o = 1'b1;
    sel_b_n_o = 1'b1;
    addr_o = 3'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // One access on either channel; read strobe held to the answer, write strobe held four cycles, then low two cycles
  task automatic access(input logic chb, input logic w, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
    int n;
    @(posedge ref_clk_i);
    sel_a_n_o <= chb;
    sel_b_n_o <= ~chb;
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= ~w;
    for (n = 0; n < 8; n++) begin
      @(posedge ref_clk_i);
      if (!w && rdata_valid_i === 1'b1) break;
      if (w && n == 3) break;
    end
    ok = (n < 8);
    q = rdata_i;
    // Released address and data lines show the inverse of the last value; selects and strobes go inactive
    sel_a_n_o <= 1'b1;
    sel_b_n_o <= 1'b1;
    addr_o <= ~a;
    wdata_o <= ~d;
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask
endmodule

// ==== ucrm_bank_test.sv ====
// Self-checking bench for the channel register bank
`timescale 1ns/1ns
module ucrm_bank_test;
  import ucrm_pkg::*;
  typedef struct packed {
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } ucrm_row_t;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sel_a_n, sel_b_n, wr, rd, rvalid, irq, tx_push, rx_pop, rx_rst, tx_rst, fifo_en;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, q, tx_data, line_control, modem_control, enhanced_function;
  logic [1:0] trig;
  logic [15:0] div;
  ucrm_core_t core;
  int n_errors = 0;
  int total_checks = 0;
  int n_push = 0;
  int n_pop = 0;
  int n_rrst = 0;
  int n_trst = 0;
  logic [7:0] last_tx = 8'h00;
  ucrm_row_t rows [9] = '{'{UCRM_ADDR_SPR, 8'hA5, 8'hA5}, '{UCRM_ADDR_SPR, 8'h5A, 8'h5A},
    '{UCRM_ADDR_LCR, 8'h1B, 8'h1B}, '{UCRM_ADDR_MCR, 8'hFF, 8'h1F}, '{UCRM_ADDR_IER, 8'hFF, 8'h0F},
    '{UCRM_ADDR_IER, 8'h00, 8'h00}, '{UCRM_ADDR_LSR, 8'h00, 8'h60}, '{UCRM_ADDR_MSR, 8'hFF, 8'h00},
    '{UCRM_ADDR_LCR, 8'h03, 8'h03}};
  logic [7:0] ier_v [4] = '{8'h08, 8'h0A, 8'h0B, 8'h0F};
  logic [7:0] isr_v [4] = '{8'hC0, 8'hC2, 8'hC4, 8'hC6};

  always #25 ref_clk_i = ~ref_clk_i;

  ucrm_host host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .rdata_valid_i(rvalid), .sel_a_n_o(sel_a_n),
    .sel_b_n_o(sel_b_n), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  ucrm_bank #(.REV_CODE(8'h01), .DEV_IDENT(8'h5A), .CHANNEL(0)) DUT (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .channel_a_select_n_i(sel_a_n), .channel_b_select_n_i(sel_b_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rdata_valid_o(rvalid), .irq_o(irq),
    .core_i(core), .tx_push_o(tx_push), .tx_data_o(tx_data), .rx_pop_o(rx_pop), .rx_fifo_reset_o(rx_rst),
    .tx_fifo_reset_o(tx_rst), .fifo_en_o(fifo_en), .rx_trigger_o(trig), .line_control_o(line_control),
    .divisor_o(div), .modem_control_o(modem_control), .enhanced_function_o(enhanced_function));

  // Pulse monitors
  always @(posedge ref_clk_i) begin
    if (tx_push === 1'b1) begin
      n_push <= n_push + 1;
      last_tx <= tx_data;
    end
    if (rx_pop === 1'b1) n_pop <= n_pop + 1;
    if (rx_rst === 1'b1) n_rrst <= n_rrst + 1;
    if (tx_rst === 1'b1) n_trst <= n_trst + 1;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d, input logic chb = 1'b0);
    logic [7:0] x;
    logic ok;
    host.access(chb, 1'b1, a, d, x, ok);
  endtask

  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    logic ok;
    host.access(1'b0, 1'b0, a, 8'h00, q, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      stop_test();
    end
    check("read data at address", {5'h00, a, q}, {5'h00, a, e});
  endtask

  task automatic wirq(input logic e);
    for (int i = 0; i < 8 && irq !== e; i++) @(posedge ref_clk_i);
    check("irq", irq, e);
    if (irq !== e) stop_test();
  endtask

  task automatic setlv(input logic [4:0] v);
    @(posedge ref_clk_i);
    core.rx_level <= v;
  endtask

  initial begin
    core = '0;
    core.tx_fifo_empty = 1'b1;
    core.tx_shift_empty = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    check("lcr out", line_control, 8'h03);
    check("divisor", div, 16'h0000);
    rc(UCRM_ADDR_ISR, 8'h01);
    $display("test reset done");
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rc(rows[i].a, rows[i].e);
    end
    check("mcr out", modem_control, 8'h1F);
    wr_reg(UCRM_ADDR_SPR, 8'h77, 1'b1);
    rc(UCRM_ADDR_SPR, 8'h5A);
    $display("test register table done");
    wr_reg(UCRM_ADDR_LCR, 8'h80);
    wr_reg(3'h0, 8'h00);
    wr_reg(3'h1, 8'h00);
    rc(3'h0, 8'h01);
    rc(3'h1, 8'h5A);
    wr_reg(3'h0, 8'h34);
    wr_reg(3'h1, 8'h12);
    check("divisor", div, 16'h1234);
    rc(3'h0, 8'h34);
    wr_reg(UCRM_ADDR_LCR, UCRM_LCR_ENH_BANK);
    wr_reg(3'h2, 8'h10);
    check("efr out", enhanced_function, 8'h10);
    rc(3'h2, 8'h10);
    wr_reg(3'h4, 8'h11);
    rc(3'h4, 8'h11);
    wr_reg(UCRM_ADDR_LCR, 8'h03);
    wr_reg(UCRM_ADDR_IER, 8'hF0);
    rc(UCRM_ADDR_IER, 8'hF0);
    wr_reg(UCRM_ADDR_MCR, 8'hE0);
    rc(UCRM_ADDR_MCR, 8'hE0);
    check("mcr out", modem_control, 8'hE0);
    wr_reg(UCRM_ADDR_IER, 8'h00);
    $display("test banks done");
    wr_reg(UCRM_ADDR_HOLD, 8'h5A);
    check("tx pushes", 16'(n_push), 16'h0001);
    check("tx data", last_tx, 8'h5A);
    wr_reg(UCRM_ADDR_ISR, 8'h06);
    check("rx resets", 16'(n_rrst), 16'h0000);
    check("tx resets", 16'(n_trst), 16'h0000);
    check("fifo enable", fifo_en, 1'b0);
    wr_reg(UCRM_ADDR_ISR, 8'h47);
    check("rx resets", 16'(n_rrst), 16'h0001);
    check("tx resets", 16'(n_trst), 16'h0001);
    check("trigger", trig, 2'h1);
    rc(UCRM_ADDR_ISR, 8'hC1);
    wr_reg(UCRM_ADDR_IER, 8'h01);
    core.rx_head_data <= 8'h3C;
    setlv(5'd3);
    core.rx_push <= 1'b1;
    @(posedge ref_clk_i);
    core.rx_push <= 1'b0;
    wirq(1'b0);
    setlv(5'd4);
    wirq(1'b1);
    rc(UCRM_ADDR_ISR, 8'hC4);
    rc(UCRM_ADDR_HOLD, 8'h3C);
    check("rx pops", 16'(n_pop), 16'h0001);
    setlv(5'd3);
    wirq(1'b0);
    rc(UCRM_ADDR_ISR, 8'hC1);
    $display("test fifo trigger done");
    @(posedge ref_clk_i);
    core.rx_push <= 1'b1;
    core.rx_overrun <= 1'b1;
    core.rx_head_err <= 3'b101;
    core.rx_err_present <= 1'b1;
    core.tx_shift_empty <= 1'b0;
    core.modem_status <= 8'h01;
    @(posedge ref_clk_i);
    core.rx_push <= 1'b0;
    core.rx_overrun <= 1'b0;
    setlv(5'd4);
    foreach (ier_v[i]) begin
      wr_reg(UCRM_ADDR_IER, ier_v[i]);
      wirq(1'b1);
      rc(UCRM_ADDR_ISR, isr_v[i]);
    end
    wr_reg(UCRM_ADDR_IER, 8'h00);
    wirq(1'b0);
    rc(UCRM_ADDR_ISR, 8'hC1);
    rc(UCRM_ADDR_LSR, 8'hB7);
    setlv(5'd0);
    core.rx_head_err <= 3'b000;
    core.rx_err_present <= 1'b0;
    core.tx_fifo_empty <= 1'b0;
    rc(UCRM_ADDR_LSR, 8'h00);
    @(posedge ref_clk_i);
    core.tx_fifo_empty <= 1'b1;
    core.tx_shift_empty <= 1'b1;
    rc(UCRM_ADDR_LSR, 8'h60);
    $display("test line status done");
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    check("divisor", div, 16'h0000);
    check("fifo enable", fifo_en, 1'b0);
    rc(UCRM_ADDR_LCR, 8'h03);
    rc(UCRM_ADDR_ISR, 8'h01);
    $display("test second reset done");
    stop_test();
  end
endmodule
